// ===== shared/tmr8_defines.vh
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH
// register word offsets (word addresses on adr_i)
`define TMR8_ADR_CTRL 4'h0
`define TMR8_ADR_COUNT 4'h1
`define TMR8_ADR_CMP 4'h2
`define TMR8_ADR_FLAGS 4'h3
`define TMR8_ADR_MASK 4'h4
`define TMR8_ADR_STROBE 4'h5
`define TMR8_ADR_ACK 4'h6
// ctrl fields
`define TMR8_CS_LSB 0
`define TMR8_CS_MSB 2
`define TMR8_WGM_LSB 3
`define TMR8_WGM_MSB 4
`define TMR8_COM_LSB 5
`define TMR8_COM_MSB 6
`define TMR8_ASYNC_BIT 7
`define TMR8_DDR_BIT 8
// flag / mask / ack / strobe bits
`define TMR8_FLG_OVF 0
`define TMR8_FLG_CMP 1
`define TMR8_STB_FORCE 0
// waveform modes
`define TMR8_WGM_NORMAL 2'h0
`define TMR8_WGM_PCPWM 2'h1
`define TMR8_WGM_CTC 2'h2
`define TMR8_WGM_FAST 2'h3
// reset value and counter ends
`define TMR8_CTRL_RST 9'h000
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`endif

// ===== hw/tmr8_tick_sel.v
`timescale 1ns/1ns
`include "tmr8_defines.vh"
// timer clock select: one-cycle tick from io clock divider, crystal pin edge or external pin edge
module tmr8_tick_sel #(
   parameter PRE_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire [2:0] cs_i,
   input wire async_sel_i,
   input wire xtal_i,
   input wire ext_i,
   output wire tick_o
);
   reg [PRE_W-1:0] pre_q;
   reg [2:0] xs_q;
   reg [2:0] es_q;
   reg tap;
   wire src_edge;
   wire xtal_rise;
   wire ext_rise;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= {PRE_W{1'b0}};
         xs_q <= 3'h0;
         es_q <= 3'h0;
      end else begin
         pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
         xs_q <= {xs_q[1:0], xtal_i};
         es_q <= {es_q[1:0], ext_i};
      end
   end
   // edges read only the second and third stages
   assign xtal_rise = xs_q[1] & ~xs_q[2];
   assign ext_rise = es_q[1] & ~es_q[2];
   assign src_edge = async_sel_i ? xtal_rise : 1'b1;
   always @* begin
      case (cs_i)
         3'h1: tap = 1'b1;
         3'h2: tap = (pre_q[2:0] == 3'h7);
         3'h3: tap = (pre_q[4:0] == 5'h1f);
         3'h4: tap = (pre_q[5:0] == 6'h3f);
         3'h5: tap = (pre_q[6:0] == 7'h7f);
         3'h6: tap = (pre_q[7:0] == 8'hff);
         3'h7: tap = async_sel_i ? (pre_q == {PRE_W{1'b1}}) : ext_rise;
         default: tap = 1'b0;
      endcase
   end
   assign tick_o = (cs_i == 3'h7 && !async_sel_i) ? tap : (tap & src_edge);
endmodule // tmr8_tick_sel

// ===== hw/tmr8_core.v
`timescale 1ns/1ns
`include "tmr8_defines.vh"
module tmr8_core (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] adr_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   input wire we_i,
   input wire [3:0] sel_i,
   input wire cyc_i,
   input wire stb_i,
   output reg ack_o,
   output reg err_o,
   input wire xtal_i,
   input wire ext_clk_i,
   input wire port_out_i,
   input wire ovf_irq_ack_i,
   input wire cmp_irq_ack_i,
   output wire pin_o,
   output wire pin_oe_n_o,
   output wire ovf_irq_o,
   output wire cmp_irq_o,
   output wire top_o,
   output wire bottom_o
);
   ////////////////////////////////////////////////////////////////////////
   reg [8:0] ctrl_q;
   reg [7:0] cnt_q;
   reg [7:0] cmp_q;
   reg [7:0] cmp_buf_q;
   reg ovf_q;
   reg cmpf_q;
   reg [1:0] mask_q;
   reg oc_q;
   reg down_q;
   reg blk_q;
   reg [7:0] cnt_d;
   reg down_d;
   reg oc_d;
   reg ovf_set;
   wire tick;
   wire [2:0] cs = ctrl_q[`TMR8_CS_MSB:`TMR8_CS_LSB];
   wire [1:0] wgm = ctrl_q[`TMR8_WGM_MSB:`TMR8_WGM_LSB];
   wire [1:0] com = ctrl_q[`TMR8_COM_MSB:`TMR8_COM_LSB];
   wire pwm = (wgm == `TMR8_WGM_FAST) || (wgm == `TMR8_WGM_PCPWM);
   wire acc = cyc_i & stb_i & ~ack_o & ~err_o;
   wire wr = acc & we_i & sel_i[0];
   wire wr_hi = acc & we_i & sel_i[1];
   wire wr_cnt = wr && adr_i == `TMR8_ADR_COUNT;
   wire wr_cmp = wr && adr_i == `TMR8_ADR_CMP;
   wire wr_flg = wr && adr_i == `TMR8_ADR_FLAGS;
   wire force_stb = wr && adr_i == `TMR8_ADR_STROBE && dat_i[`TMR8_STB_FORCE] && !pwm;
   wire mapped = adr_i <= `TMR8_ADR_ACK;
   wire at_max = (cnt_q == `TMR8_MAX);
   wire at_bot = (cnt_q == `TMR8_BOTTOM);
   wire match = (cnt_q == cmp_q) && !blk_q;
   wire cmp_evt = tick & match;
   ////////////////////////////////////////////////////////////////////////
   tmr8_tick_sel #(.PRE_W(10)) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cs_i(cs),
      .async_sel_i(ctrl_q[`TMR8_ASYNC_BIT]),
      .xtal_i(xtal_i),
      .ext_i(ext_clk_i),
      .tick_o(tick)
   );
   assign top_o = at_max;
   assign bottom_o = at_bot;
   ////////////////////////////////////////////////////////////////////////
   // counter sequence, chosen by waveform bits alone
   always @* begin
      cnt_d = cnt_q;
      down_d = down_q;
      ovf_set = 1'b0;
      if (tick) begin
         case (wgm)
            `TMR8_WGM_NORMAL: begin
               cnt_d = cnt_q + 8'h01;
               ovf_set = at_max;
            end
            `TMR8_WGM_CTC: begin
               cnt_d = match ? `TMR8_BOTTOM : cnt_q + 8'h01;
               ovf_set = at_max;
            end
            `TMR8_WGM_FAST: begin
               cnt_d = cnt_q + 8'h01;
               ovf_set = at_max;
            end
            `TMR8_WGM_PCPWM: begin
               if (!down_q && at_max) begin
                  down_d = 1'b1;
                  cnt_d = cnt_q - 8'h01;
               end else if (down_q && at_bot) begin
                  down_d = 1'b0;
                  cnt_d = cnt_q + 8'h01;
               end else begin
                  cnt_d = down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
               end
               ovf_set = down_q && (cnt_q == 8'h01);
            end
            default: cnt_d = cnt_q;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // waveform output: current mode bits apply at the very next match
   always @* begin
      oc_d = oc_q;
      if (force_stb || (cmp_evt && !pwm)) begin
         case (com)
            2'h1: oc_d = ~oc_q;
            2'h2: oc_d = 1'b0;
            2'h3: oc_d = 1'b1;
            default: oc_d = oc_q;
         endcase
      end else if (tick && wgm == `TMR8_WGM_FAST && com[1]) begin
         if (match)
            oc_d = com[0];
         else if (at_max)
            oc_d = ~com[0];
      end else if (cmp_evt && wgm == `TMR8_WGM_FAST && com == 2'h1) begin
         oc_d = ~oc_q;
      end else if (cmp_evt && wgm == `TMR8_WGM_PCPWM && com[1]) begin
         oc_d = down_q ^ com[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `TMR8_CTRL_RST;
         cnt_q <= `TMR8_BOTTOM;
         cmp_q <= `TMR8_BOTTOM;
         cmp_buf_q <= `TMR8_BOTTOM;
         ovf_q <= 1'b0;
         cmpf_q <= 1'b0;
         mask_q <= 2'h0;
         oc_q <= 1'b0;
         down_q <= 1'b0;
         blk_q <= 1'b0;
      end else begin
         down_q <= down_d;
         oc_q <= oc_d;
         // single-cycle update, no partial state seen by the counter
         if (wr_cnt) begin
            cnt_q <= dat_i[7:0];
            blk_q <= 1'b1;
         end else begin
            cnt_q <= cnt_d;
            if (tick)
               blk_q <= 1'b0;
         end
         if (wr && adr_i == `TMR8_ADR_CTRL)
            ctrl_q[7:0] <= dat_i[7:0];
         if (wr_hi && adr_i == `TMR8_ADR_CTRL)
            ctrl_q[8] <= dat_i[8];
         if (wr && adr_i == `TMR8_ADR_MASK)
            mask_q <= dat_i[1:0];
         if (wr_cmp)
            cmp_buf_q <= dat_i[7:0];
         if (wr_cmp && !pwm)
            cmp_q <= dat_i[7:0];
         else if (pwm && tick && ((wgm == `TMR8_WGM_FAST && at_max) ||
                                  (wgm == `TMR8_WGM_PCPWM && at_max && !down_q)))
            cmp_q <= cmp_buf_q;
         else if (!pwm)
            cmp_buf_q <= wr_cmp ? dat_i[7:0] : cmp_q;
         // hardware set wins over clear
         if (tick && ovf_set)
            ovf_q <= 1'b1;
         else if (ovf_irq_ack_i || (wr_flg && dat_i[`TMR8_FLG_OVF]))
            ovf_q <= 1'b0;
         if (cmp_evt)
            cmpf_q <= 1'b1;
         else if (cmp_irq_ack_i || (wr_flg && dat_i[`TMR8_FLG_CMP]))
            cmpf_q <= 1'b0;
      end
   end
   assign ovf_irq_o = ovf_q & mask_q[`TMR8_FLG_OVF];
   assign cmp_irq_o = cmpf_q & mask_q[`TMR8_FLG_CMP];
   ////////////////////////////////////////////////////////////////////////
   // pin override; direction stays with the direction bit
   assign pin_o = (com != 2'h0) ? oc_q : port_out_i;
   assign pin_oe_n_o = ~ctrl_q[`TMR8_DDR_BIT];
   ////////////////////////////////////////////////////////////////////////
   // wishbone classic slave, one wait state, err on unmapped
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= acc & mapped;
         err_o <= acc & ~mapped;
         dat_o <= 32'h00000000;
         if (acc && !we_i) begin
            case (adr_i)
               `TMR8_ADR_CTRL: dat_o <= {23'h0, ctrl_q};
               `TMR8_ADR_COUNT: dat_o <= {24'h0, cnt_q};
               `TMR8_ADR_CMP: dat_o <= {24'h0, pwm ? cmp_buf_q : cmp_q};
               `TMR8_ADR_FLAGS: dat_o <= {30'h0, cmpf_q, ovf_q};
               `TMR8_ADR_MASK: dat_o <= {30'h0, mask_q};
               `TMR8_ADR_ACK: dat_o <= {29'h0, down_q, at_max, oc_q};
               default: dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // tmr8_core

// ===== verification/tmr8_core_asserts.sv
`timescale 1ns/1ns
module tmr8_chk (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] adr_i,
   input wire [31:0] dat_i,
   input wire we_i,
   input wire [3:0] sel_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire err_o,
   input wire port_out_i,
   input wire pin_o,
   input wire pin_oe_n_o,
   input wire ovf_irq_o,
   input wire cmp_irq_o,
   input wire top_o,
   input wire bottom_o
);
   wire take = cyc_i && stb_i && !ack_o && !err_o;
   wire mwr = ack_o && we_i && adr_i == 4'h4 && sel_i[0];
   logic [1:0] com_q;
   logic [2:0] cs_q;
   // mirror of output mode and clock select
   always @(posedge clk_i) begin
      if (rst_i) begin
         com_q <= 2'h0;
         cs_q <= 3'h0;
      end else if (take && we_i && adr_i == 4'h0 && sel_i[0]) begin
         com_q <= dat_i[6:5];
         cs_q <= dat_i[2:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_resp; take |=> ack_o != err_o; endproperty
   a_resp: assert property (p_resp) else $error("no single answer");
   property p_ack1; ack_o |=> !ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_err; take && adr_i > 4'h6 |=> err_o && !ack_o; endproperty
   a_err: assert property (p_err) else $error("no error answer");
   property p_oe; $changed(pin_oe_n_o) |-> ack_o && we_i && adr_i == 4'h0; endproperty
   a_oe: assert property (p_oe) else $error("direction moved alone");
   property p_pin; com_q == 2'h0 |-> pin_o == port_out_i; endproperty
   a_pin: assert property (p_pin) else $error("port not passed");
   property p_mo; mwr && !dat_i[0] |-> !ovf_irq_o; endproperty
   a_mo: assert property (p_mo) else $error("masked overflow irq");
   property p_mc; mwr && !dat_i[1] |-> !cmp_irq_o; endproperty
   a_mc: assert property (p_mc) else $error("masked compare irq");
   property p_tb; !(top_o && bottom_o); endproperty
   a_tb: assert property (p_tb) else $error("top and bottom");
   property p_ovb; $rose(ovf_irq_o) && !ack_o |-> bottom_o; endproperty
   a_ovb: assert property (p_ovb) else $error("overflow away from bottom");
   property p_stop;
      cs_q == 3'h0 && !cyc_i && !$past(cyc_i) |=> $stable({top_o, bottom_o});
   endproperty
   a_stop: assert property (p_stop) else $error("stopped count moved");
endmodule // tmr8_chk
bind tmr8_core tmr8_chk chk_u (.clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i, .cyc_i,
   .stb_i, .ack_o, .err_o, .port_out_i, .pin_o, .pin_oe_n_o, .ovf_irq_o, .cmp_irq_o,
   .top_o, .bottom_o);

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, port = 0, oack = 0, cack = 0;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0, q;
   logic eb = 0, p;
   logic xtal = 0, ext = 0;
   wire [31:0] dat_o;
   wire ack_o, err_o, pin_o, pin_oe_n_o, ovf_irq_o, cmp_irq_o, top_o, bottom_o;
   int failures = 0, comparisons = 0, ncyc = 0, n;
   logic [3:0] ra[6] = '{4'h2, 4'h4, 4'h1, 4'h3, 4'h6, 4'h0};
   logic [31:0] rd[6] = '{32'ha5, 32'h3, 32'h5a, 32'h3, 32'h7, 32'h1f8};
   logic [31:0] re[6] = '{32'ha5, 32'h3, 32'h5a, 32'h0, 32'h0, 32'h1f8};
   always #50 clk_i = ~clk_i;
   tmr8_core dut_u (.clk_i, .rst_i, .adr_i(adr), .dat_i(dat), .dat_o, .we_i(we),
      .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o, .err_o, .xtal_i(xtal),
      .ext_clk_i(ext), .port_out_i(port), .ovf_irq_ack_i(oack), .cmp_irq_ack_i(cack),
      .pin_o, .pin_oe_n_o, .ovf_irq_o, .cmp_irq_o, .top_o, .bottom_o);
   task chk(input [31:0] s, input [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // request held until ack or err is seen high at a rising edge
   task wb(input [3:0] a, input w, input [31:0] d);
      @(posedge clk_i);
      adr <= a; we <= w; dat <= d; cyc <= 1; stb <= 1;
      do begin
         @(posedge clk_i);
      end while (!(ack_o | err_o));
      q = dat_o;
      eb = err_o;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task pulse(input bit c);
      @(posedge clk_i);
      if (c) cack <= 1; else oack <= 1;
      @(posedge clk_i);
      cack <= 0; oack <= 0;
      @(negedge clk_i);
   endtask
   // k rising edges on crystal and external pins, then time to settle
   task edges(input int k);
      repeat (k) begin
         @(posedge clk_i);
         xtal <= 1; ext <= 1;
         repeat (2) @(posedge clk_i);
         xtal <= 0; ext <= 0;
         @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      ncyc++;
      if (ncyc > 5000) begin
         failures++;
         give_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      chk(bottom_o, 1);
      chk(pin_oe_n_o, 1);
      for (int i = 0; i < 6; i++) begin
         wb(ra[i], 1, rd[i]);
         wb(ra[i], 0, 0);
         chk(q, re[i]);
      end
      // mid-run reset, held three edges
      @(posedge clk_i);
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      chk(bottom_o, 1);
      chk(pin_oe_n_o, 1);
      wb(1, 0, 0);
      chk(q, 0);
      wb(0, 1, 0); wb(4, 1, 3); wb(1, 1, 32'hff);
      chk(top_o, 1);
      wb(1, 1, 32'hf0); wb(0, 1, 1);
      n = 0;
      while (ovf_irq_o !== 1 && n < 600) begin
         @(negedge clk_i);
         n++;
      end
      chk(bottom_o, 1);
      wb(0, 1, 0); pulse(0);
      chk(ovf_irq_o, 0);
      wb(2, 1, 5);
      wb(1, 1, 0);
      wb(3, 1, 3); wb(0, 1, 32'h020);
      wb(5, 1, 1);
      chk(pin_o, 1);
      chk(pin_oe_n_o, 1);
      wb(0, 1, 32'h131);
      for (int j = 0; j < 2; j++) begin
         p = pin_o;
         n = 0;
         while (pin_o === p && n < 50) begin
            @(negedge clk_i);
            n++;
         end
      end
      chk(n, 6);
      chk(cmp_irq_o, 1);
      wb(0, 1, 32'h130); pulse(1);
      chk(cmp_irq_o, 0);
      chk(pin_oe_n_o, 0);
      p = pin_o;
      wb(0, 1, 32'h120);
      chk(pin_o, p);
      wb(5, 1, 1);
      chk(pin_o, !p);
      wb(3, 0, 0);
      chk(q[1], 0);
      wb(2, 1, 7); wb(1, 1, 7); wb(0, 1, 1); wb(0, 1, 0); wb(3, 0, 0);
      chk(q[1], 0);
      wb(1, 1, 0); wb(0, 1, 32'h81);
      edges(4);
      wb(0, 1, 0); wb(1, 0, 0);
      chk(q, 4);
      wb(1, 1, 0); wb(0, 1, 7);
      edges(3);
      wb(0, 1, 0); wb(1, 0, 0);
      chk(q, 3);
      wb(2, 1, 32'h10); wb(0, 1, 32'h18); wb(2, 1, 32'h20); wb(1, 1, 32'hf); wb(3, 1, 3);
      wb(0, 1, 32'h19); wb(0, 1, 32'h18); wb(3, 0, 0);
      chk(q[1], 1);
      wb(2, 0, 0);
      chk(q, 32'h20);
      wb(1, 1, 32'hfe); wb(0, 1, 32'h09); wb(0, 1, 32'h08); wb(6, 0, 0);
      chk(q[2], 1);
      wb(1, 0, 0);
      chk(q, 32'hfd);
      wb(4, 1, 0);
      port <= 1;
      @(negedge clk_i);
      chk(pin_o, 1);
      wb(4'h9, 0, 0);
      chk(eb, 1);
      give_verdict;
   end
endmodule // tb_top
